//--- logic/debug_data_channel.sv
// Debug data mailbox between the processor and the test port debugger.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module debug_data_channel (
   // Core clock, reset and enable.
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   // Processor register port.
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // Fuse and lock levels.
   input  wire logic       debug_enable_fuse,
   input  wire logic       test_port_enable_fuse,
   input  wire logic       lock_bits_set,
   // Test access port.
   input  wire logic       tck,
   input  wire logic       tms,
   input  wire logic       tdi,
   output logic            tdo,
   output logic            tdo_oe_b,
   // Status.
   output logic            test_port_enabled
);

   typedef enum logic [15:0] {
      TLR  = 16'h0001,
      RTI  = 16'h0002,
      SDRS = 16'h0004,
      CDR  = 16'h0008,
      SDR  = 16'h0010,
      E1DR = 16'h0020,
      PDR  = 16'h0040,
      E2DR = 16'h0080,
      UDR  = 16'h0100,
      SIRS = 16'h0200,
      CIR  = 16'h0400,
      SIR  = 16'h0800,
      E1IR = 16'h1000,
      PIR  = 16'h2000,
      E2IR = 16'h4000,
      UIR  = 16'h8000
   } tap_state_e;

   // ---------------- Core clock domain ----------------

   logic       rst_s1_q;
   logic       rst_s2_q;
   logic       fen_s1_q;
   logic       fen_s2_q;
   logic       ten_s1_q;
   logic       ten_s2_q;
   logic       lck_s1_q;
   logic       lck_s2_q;
   logic       acc_s1_q;
   logic       acc_s2_q;
   logic       ack_s1_q;
   logic       ack_s2_q;
   logic       clr_s1_q;
   logic       clr_s2_q;
   logic       clr_s3_q;
   logic [7:0] mailbox_q;
   logic [7:0] shared_io_q;
   logic       dirty_q;
   logic       port_disable_q;
   logic       req_q;
   logic [8:0] xfer_q;
   logic       ocd_ok;
   logic       route_mbox;
   logic       clr_evt;
   logic       hit_shared;
   logic       hit_mcu_control_status_register;
   // Test clock registers that the core synchronises.
   logic       ack_q;
   logic       acc_en_q;
   logic       clr_tgl_q;

   // Reset is asserted at once and released through two flip-flops.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Pin levels and signals from the test clock domain are synchronised.
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         fen_s1_q <= 1'b0;
         fen_s2_q <= 1'b0;
         ten_s1_q <= 1'b0;
         ten_s2_q <= 1'b0;
         lck_s1_q <= 1'b1;
         lck_s2_q <= 1'b1;
         acc_s1_q <= 1'b0;
         acc_s2_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         clr_s1_q <= 1'b0;
         clr_s2_q <= 1'b0;
         clr_s3_q <= 1'b0;
      end else if (clk_en) begin
         fen_s1_q <= debug_enable_fuse;
         fen_s2_q <= fen_s1_q;
         ten_s1_q <= test_port_enable_fuse;
         ten_s2_q <= ten_s1_q;
         lck_s1_q <= lock_bits_set;
         lck_s2_q <= lck_s1_q;
         acc_s1_q <= acc_en_q;
         acc_s2_q <= acc_s1_q;
         ack_s1_q <= ack_q;
         ack_s2_q <= ack_s1_q;
         clr_s1_q <= clr_tgl_q;
         clr_s2_q <= clr_s1_q;
         clr_s3_q <= clr_s2_q;
      end
   end

   // A locked part offers no back door, so the lock overrides the fuse.
   assign ocd_ok     = fen_s2_q && !lck_s2_q;
   assign route_mbox = ocd_ok && acc_s2_q;
   assign clr_evt    = (clr_s2_q ^ clr_s3_q) && ocd_ok;
   assign hit_shared = (addr == debug_data_channel_pkg::SHARED_ADDR);
   assign hit_mcu_control_status_register = (addr == debug_data_channel_pkg::CTRL_STATUS_ADDR);

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         mailbox_q <= debug_data_channel_pkg::MAILBOX_RST;
      end else if (clk_en && wr && hit_shared && route_mbox) begin
         mailbox_q <= wdata;
      end
   end

   // The set wins over a clear arriving in the same cycle.
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         dirty_q <= debug_data_channel_pkg::DIRTY_RST;
      end else if (clk_en) begin
         if (wr && hit_shared && route_mbox) begin
            dirty_q <= 1'b1;
         end else if (clr_evt) begin
            dirty_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         shared_io_q <= debug_data_channel_pkg::SHARED_RST;
      end else if (clk_en && wr && hit_shared && !route_mbox) begin
         shared_io_q <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         port_disable_q <= debug_data_channel_pkg::DISABLE_RST;
      end else if (clk_en && wr && hit_mcu_control_status_register) begin
         port_disable_q <= wdata[debug_data_channel_pkg::PORT_DISABLE_POS];
      end
   end

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         test_port_enabled <= 1'b0;
      end else if (clk_en) begin
         test_port_enabled <= ten_s2_q && !port_disable_q;
      end
   end

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         rdata <= debug_data_channel_pkg::UNMAPPED_RD;
      end else if (clk_en) begin
         rdata <= debug_data_channel_pkg::UNMAPPED_RD;
         if (rd && hit_shared && route_mbox) begin
            rdata <= {dirty_q, mailbox_q[6:0]};
         end else if (rd && hit_shared) begin
            rdata <= shared_io_q;
         end else if (rd && hit_mcu_control_status_register) begin
            rdata[debug_data_channel_pkg::PORT_DISABLE_POS] <= port_disable_q;
         end
      end
   end

   // The snapshot only moves while no handshake is open, so the test
   // clock side always samples a word that stands still.
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         req_q  <= 1'b0;
         xfer_q <= 9'h000;
      end else if (clk_en && (ack_s2_q == req_q)) begin
         xfer_q <= {dirty_q && ocd_ok, mailbox_q};
         req_q  <= !req_q;
      end
   end

   // ---------------- Test clock domain ----------------

   logic       trst_s1_q;
   logic       trst_s2_q;
   logic       ten_t1_q;
   logic       ten_t2_q;
   logic       req_t1_q;
   logic       req_t2_q;
   logic [8:0] shadow_q;
   tap_state_e state_q;
   tap_state_e state_d;
   logic [3:0] ir_q;
   logic [3:0] ir_sh_q;
   logic [8:0] dr_q;
   logic [3:0] ir_sh_d;
   logic [8:0] dr_d;

   always_ff @(posedge tck or negedge rst_b) begin
      if (!rst_b) begin
         trst_s1_q <= 1'b0;
         trst_s2_q <= 1'b0;
      end else begin
         trst_s1_q <= 1'b1;
         trst_s2_q <= trst_s1_q;
      end
   end

   always_ff @(posedge tck or negedge trst_s2_q) begin
      if (!trst_s2_q) begin
         ten_t1_q <= 1'b0;
         ten_t2_q <= 1'b0;
         req_t1_q <= 1'b0;
         req_t2_q <= 1'b0;
      end else begin
         ten_t1_q <= test_port_enabled;
         ten_t2_q <= ten_t1_q;
         req_t1_q <= req_q;
         req_t2_q <= req_t1_q;
      end
   end

   always_ff @(posedge tck or negedge trst_s2_q) begin
      if (!trst_s2_q) begin
         ack_q    <= 1'b0;
         shadow_q <= 9'h000;
      end else if (req_t2_q != ack_q) begin
         shadow_q <= xfer_q;
         ack_q    <= req_t2_q;
      end
   end

   // Only clock, mode select, data in and data out take part.
   always_comb begin
      state_d = state_q;
      case (state_q)
         TLR:     state_d = tms ? TLR  : RTI;
         RTI:     state_d = tms ? SDRS : RTI;
         SDRS:    state_d = tms ? SIRS : CDR;
         CDR:     state_d = tms ? E1DR : SDR;
         SDR:     state_d = tms ? E1DR : SDR;
         E1DR:    state_d = tms ? UDR  : PDR;
         PDR:     state_d = tms ? E2DR : PDR;
         E2DR:    state_d = tms ? UDR  : SDR;
         UDR:     state_d = tms ? SDRS : RTI;
         SIRS:    state_d = tms ? TLR  : CIR;
         CIR:     state_d = tms ? E1IR : SIR;
         SIR:     state_d = tms ? E1IR : SIR;
         E1IR:    state_d = tms ? UIR  : PIR;
         PIR:     state_d = tms ? E2IR : PIR;
         E2IR:    state_d = tms ? UIR  : SIR;
         UIR:     state_d = tms ? SDRS : RTI;
         default: state_d = TLR;
      endcase
   end

   // Next shift values, so tdo shows the bit that stands after this edge.
   always_comb begin
      ir_sh_d = ir_sh_q;
      dr_d    = dr_q;
      if (state_q == CIR) begin
         ir_sh_d = debug_data_channel_pkg::IR_CAPTURE;
      end else if (state_q == SIR) begin
         ir_sh_d = {tdi, ir_sh_q[3:1]};
      end
      if (state_q == CDR) begin
         case (ir_q)
            debug_data_channel_pkg::INS_MAILBOX: dr_d = shadow_q;
            debug_data_channel_pkg::INS_ACCESS:  dr_d = {8'h00, acc_en_q};
            default:                             dr_d = 9'h000;
         endcase
      end else if (state_q == SDR) begin
         case (ir_q)
            debug_data_channel_pkg::INS_MAILBOX: dr_d = {tdi, dr_q[8:1]};
            default:                             dr_d = {8'h00, tdi};
         endcase
      end
   end

   // A disabled port is held in its reset state.
   always_ff @(posedge tck or negedge trst_s2_q) begin
      if (!trst_s2_q) begin
         state_q <= TLR;
      end else if (!ten_t2_q) begin
         state_q <= TLR;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge tck or negedge trst_s2_q) begin
      if (!trst_s2_q) begin
         ir_q    <= debug_data_channel_pkg::INS_BYPASS;
         ir_sh_q <= debug_data_channel_pkg::IR_CAPTURE;
      end else if (state_q == TLR) begin
         ir_q <= debug_data_channel_pkg::INS_BYPASS;
      end else if (state_q == CIR || state_q == SIR) begin
         ir_sh_q <= ir_sh_d;
      end else if (state_q == UIR) begin
         ir_q <= ir_sh_q;
      end
   end

   always_ff @(posedge tck or negedge trst_s2_q) begin
      if (!trst_s2_q) begin
         dr_q <= 9'h000;
      end else begin
         dr_q <= dr_d;
      end
   end

   // Access enable drops with the port so a stale grant never lingers.
   always_ff @(posedge tck or negedge trst_s2_q) begin
      if (!trst_s2_q) begin
         acc_en_q <= 1'b0;
      end else if (state_q == TLR) begin
         acc_en_q <= 1'b0;
      end else if (state_q == UDR && ir_q == debug_data_channel_pkg::INS_ACCESS) begin
         acc_en_q <= dr_q[0];
      end
   end

   // Finishing a read of fresh data clears the dirty flag in the core.
   always_ff @(posedge tck or negedge trst_s2_q) begin
      if (!trst_s2_q) begin
         clr_tgl_q <= 1'b0;
      end else if (state_q == UDR && ir_q == debug_data_channel_pkg::INS_MAILBOX
                   && shadow_q[8]) begin
         clr_tgl_q <= !clr_tgl_q;
      end
   end

   always_ff @(posedge tck or negedge trst_s2_q) begin
      if (!trst_s2_q) begin
         tdo      <= 1'b0;
         tdo_oe_b <= 1'b1;
      end else begin
         tdo      <= (state_d == SIR) ? ir_sh_d[0] : dr_d[0];
         tdo_oe_b <= !((state_d == SIR) || (state_d == SDR));
      end
   end

endmodule

//--- logic/debug_data_channel_pkg.sv
// Constants shared by the debug data channel and its bench.
// Notes on behaviour
// - Processor write stores byte in mailbox.
// - Same write sets the dirty flag.
// - Read returns low seven bits, dirty on top.
// - Mailbox reachable only with fuse and debugger enable.
// - Otherwise accesses go to ordinary location.
// - Test port uses only four test signals.
// - Port enabled by fuse and cleared disable bit.
// - Any lock bit keeps debug system off; the code gates only the mailbox path with it, and the test port still enables.
package debug_data_channel_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned IR_W   = 4;
   localparam int unsigned DR_W   = 9;

   // Register offsets on the processor port.
   localparam logic [7:0] SHARED_ADDR = 8'h31;
   localparam logic [7:0] CTRL_STATUS_ADDR = 8'h34;

   // Field positions.
   localparam int unsigned DIRTY_POS      = 7;
   localparam int unsigned PORT_DISABLE_POS = 7;

   // Values after reset.
   localparam logic [7:0] MAILBOX_RST = 8'h00;
   localparam logic [7:0] SHARED_RST  = 8'h00;
   localparam logic       DIRTY_RST   = 1'b0;
   localparam logic       DISABLE_RST = 1'b0;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // Test port instruction codes and capture pattern.
   localparam logic [3:0] INS_MAILBOX = 4'h4;
   localparam logic [3:0] INS_ACCESS  = 4'h5;
   localparam logic [3:0] INS_BYPASS  = 4'hf;
   localparam logic [3:0] IR_CAPTURE  = 4'h1;

endpackage

//--- test/ddc_checker.sv
// Port checks for the debug data channel.
`timescale 1ns/1ps
module ddc_checker (
   // Core side.
   input wire logic       clk, rst_b, clk_en, wr, rd,
   input wire logic [7:0] addr, wdata, rdata,
   // Fuses, lock and test port.
   input wire logic       debug_enable_fuse, test_port_enable_fuse, lock_bits_set,
   input wire logic       tck, tdo_oe_b, test_port_enabled
);
   localparam logic [7:0] SA = debug_data_channel_pkg::SHARED_ADDR;
   localparam logic [7:0] CA = debug_data_channel_pkg::CTRL_STATUS_ADDR;
   wire w_sh = clk_en && wr && addr == SA;
   wire r_sh = clk_en && rd && addr == SA;
   wire w_cs = clk_en && wr && addr == CA;
   wire r_cs = clk_en && rd && addr == CA;
   wire off  = lock_bits_set || !debug_enable_fuse;

   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
      $past(clk_en) && !$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
   a_shared_readback: assert property (@(posedge clk) disable iff (!rst_b)
      w_sh ##1 r_sh |=> rdata[6:0] == $past(wdata[6:0], 2)) else $error("low bits lost");
   a_locked_ordinary: assert property (@(posedge clk) disable iff (!rst_b)
      off[*4] ##0 w_sh ##1 r_sh |=> rdata == $past(wdata, 2)) else $error("mailbox hit");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && rd && addr != SA && addr != CA |=> rdata == 8'h00) else $error("unmapped");
   a_ctrl_readback: assert property (@(posedge clk) disable iff (!rst_b)
      w_cs ##1 r_cs |=> rdata == {$past(wdata[7], 2), 7'h00}) else $error("ctrl read");
   a_fuse_gates_port: assert property (@(posedge clk) disable iff (!rst_b)
      (clk_en && !test_port_enable_fuse)[*5] |-> !test_port_enabled) else $error("no fuse");
   a_disable_blocks: assert property (@(posedge clk) disable iff (!rst_b)
      w_cs && wdata[7] |-> ##3 !test_port_enabled) else $error("disable bit ignored");
   a_released_pin: assert property (@(posedge tck) disable iff (!rst_b)
      !test_port_enabled[*6] |-> tdo_oe_b) else $error("tdo driven while off");
endmodule
bind debug_data_channel ddc_checker chk (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
   .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata), .tck(tck),
   .debug_enable_fuse(debug_enable_fuse), .test_port_enable_fuse(test_port_enable_fuse),
   .lock_bits_set(lock_bits_set), .tdo_oe_b(tdo_oe_b), .test_port_enabled(test_port_enabled));

//--- test/tap_host.sv
// Debugger host model on the four test port pins.
`timescale 1ns/1ps
module tap_host (
   // Only these four pins take part.
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // The clock stands low between frames, so tdo is sampled just before each rise.
   task automatic pulse(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #6 o = tdo;
      tck = 1'b1;
      #6 tck = 1'b0;
   endtask
   task automatic tap_reset();
      logic o;
      repeat (7) pulse(1'b1, tdi, o);
      pulse(1'b0, tdi, o);
   endtask
   task automatic idle(input int n);
      logic o;
      repeat (n) pulse(1'b0, tdi, o);
   endtask
   task automatic scan(input logic ir, input int n, input logic [8:0] din,
                       output logic [8:0] dout);
      logic o;
      dout = 9'h000;
      pulse(1'b1, tdi, o);
      if (ir) pulse(1'b1, tdi, o);
      pulse(1'b0, tdi, o);
      pulse(1'b0, tdi, o);
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, din[i], o);
         dout[i] = o;
      end
      pulse(1'b1, tdi, o);
      pulse(1'b0, tdi, o);
      tdi = ~tdi;
   endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the debug data channel.
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] SA = debug_data_channel_pkg::SHARED_ADDR;
   localparam logic [7:0] CA = debug_data_channel_pkg::CTRL_STATUS_ADDR;
   logic        clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
   logic        den = 1'b0, pen = 1'b0, lck = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, r, b;
   logic [8:0]  sdo;
   logic        tck, tms, tdi, tdo, tdo_oe_b, ten;
   logic [31:0] seed = 32'd99618;
   int          fail_count = 0, cmp_count = 0;
   always #20 clk = ~clk;
   debug_data_channel uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .debug_enable_fuse(den),
      .test_port_enable_fuse(pen), .lock_bits_set(lck), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe_b(tdo_oe_b), .test_port_enabled(ten));
   tap_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] mbox_view(logic [7:0] v, logic d);
      return {d, v[6:0]};
   endfunction
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check({1'b0, rdata}, {1'b0, e});
      @(posedge clk);
   endtask
   // Enabling needs test clock edges, so the wait keeps the port clocked.
   task automatic wait_en(input logic v);
      int n;
      n = 0;
      while (ten !== v && n < 40) begin
         host.tap_reset();
         n++;
      end
      check({8'h00, ten}, {8'h00, v});
      if (ten !== v) tally_and_finish();
      @(posedge clk);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      host.tap_reset();
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      host.tap_reset();
      wait_en(1'b0);
      rd_chk(CA, 8'h00);
      r = rnd();
      rd_chk((r == SA || r == CA) ? 8'h00 : r, 8'h00);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         den <= k[0];
         lck <= k[1];
         b = rnd();
         repeat (4) @(posedge clk);
         wr_reg(SA, b);
         rd_chk(SA, b);
      end
      $display("test routing done");
      pen <= 1'b1;
      wait_en(1'b1);
      wr_reg(CA, 8'h80);
      rd_chk(CA, 8'h80);
      check({8'h00, ten}, 9'h000);
      wr_reg(CA, 8'h00);
      wait_en(1'b1);
      $display("test port enable done");
      lck <= 1'b0;
      host.scan(1'b1, 4, 9'h005, sdo);
      check({5'h00, sdo[3:0]}, {5'h00, debug_data_channel_pkg::IR_CAPTURE});
      host.scan(1'b0, 1, 9'h001, sdo);
      host.scan(1'b1, 4, 9'h004, sdo);
      host.scan(1'b0, 9, 9'h000, sdo);
      check(sdo, 9'h000);
      for (int j = 0; j < 3; j++) begin
         b = (j == 0) ? (rnd() & 8'h7f) : rnd();
         wr_reg(SA, b);
         rd_chk(SA, mbox_view(b, 1'b1));
         host.idle(12);
         host.scan(1'b0, 9, 9'h000, sdo);
         check(sdo, {1'b1, b});
         repeat (6) @(posedge clk);
         rd_chk(SA, mbox_view(b, 1'b0));
      end
      lck <= 1'b1;
      b = rnd();
      repeat (4) @(posedge clk);
      wr_reg(SA, b);
      rd_chk(SA, b);
      $display("test mailbox done");
      tally_and_finish();
   end
endmodule
